// ### bench/lbtd_chk.sv
// port checker for the lin trigger decoder
`timescale 1ns/1ps
`default_nettype none
module lbtd_chk (
	input wire logic sys_clk, // clock
	input wire logic rst_b, // reset
	input wire logic [1:0] linStd, // standard
	input wire logic [14:0] bitRate, // asked rate
	input wire logic [2:0] trigType, // mode
	input wire logic [1:0] idCond, // id test
	input wire logic [5:0] identLowerBound, // low
	input wire logic [5:0] identUpperBound, // high
	input wire logic enParityErr, // enable
	input wire logic enSyncErr, // enable
	input wire logic enChecksumErr, // enable
	input wire logic trigOut, // trigger
	input wire logic [7:0] protectedIdent, // ident
	input wire logic parityErr, // pulse
	input wire logic syncErr, // pulse
	input wire logic checksumErr, // pulse
	input wire logic wakeSeen, // pulse
	input wire logic [14:0] bitRateUsed // rate
);
	// ****
	// checks
	// ****
	wire logic [5:0] id6 = protectedIdent[5:0];
	wire logic inRng = id6 >= identLowerBound && id6 <= identUpperBound;
	wire logic idOk = idCond[1] ? inRng ^ idCond[0] : (id6 == identLowerBound) ^ idCond[0];
	wire logic parBad = protectedIdent[7:6] != {~(id6[1] ^ id6[3] ^ id6[4] ^ id6[5]), id6[0] ^ id6[1] ^ id6[2] ^ id6[4]};
	wire logic anyErr = parityErr && enParityErr || syncErr && enSyncErr || checksumErr && enChecksumErr;
	// four cycles: outputs stay zero for two edges after reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_j2602;
		(linStd == 2'h2) [*4] |-> bitRateUsed == lbtd_pkg::J2602_RATE_BPS;
	endproperty
	a_j2602: assert property (p_j2602) else $error("rate not forced");
	property p_clamp;
		(linStd != 2'h2 && bitRate > lbtd_pkg::MAX_RATE_BPS) [*4] |-> bitRateUsed == lbtd_pkg::MAX_RATE_BPS;
	endproperty
	a_clamp: assert property (p_clamp) else $error("rate not clamped");
	property p_rate;
		(linStd != 2'h2 && $stable(bitRate) && bitRate <= lbtd_pkg::MAX_RATE_BPS) [*4] |-> bitRateUsed == bitRate;
	endproperty
	a_rate: assert property (p_rate) else $error("rate not taken");
	property p_idTrig;
		trigType == 3'h1 && trigOut |-> idOk;
	endproperty
	a_idTrig: assert property (p_idTrig) else $error("id trigger without match");
	property p_parity;
		parityErr |-> parBad;
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag on good ident");
	property p_errTrig;
		trigType == 3'h4 |-> trigOut == anyErr;
	endproperty
	a_errTrig: assert property (p_errTrig) else $error("error trigger mismatch");
	property p_wake;
		trigType == 3'h3 |-> trigOut == wakeSeen;
	endproperty
	a_wake: assert property (p_wake) else $error("wake trigger mismatch");
	property p_pulse;
		trigOut |=> !trigOut;
	endproperty
	a_pulse: assert property (p_pulse) else $error("trigger longer than a cycle");
	c_id: cover property (trigType == 3'h1 && trigOut);
	c_wake: cover property (wakeSeen);
	c_clamp: cover property (bitRateUsed == lbtd_pkg::MAX_RATE_BPS);
endmodule : lbtd_chk
bind lbtd_decoder lbtd_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .linStd(linStd), .bitRate(bitRate),
	.trigType(trigType), .idCond(idCond), .identLowerBound(identLowerBound), .identUpperBound(identUpperBound),
	.enParityErr(enParityErr), .enSyncErr(enSyncErr), .enChecksumErr(enChecksumErr), .trigOut(trigOut),
	.protectedIdent(protectedIdent), .parityErr(parityErr), .syncErr(syncErr), .checksumErr(checksumErr),
	.wakeSeen(wakeSeen), .bitRateUsed(bitRateUsed));
`default_nettype wire

// ### bench/lbtd_lin_node.sv
// lin commander model driving the bus line
`timescale 1ns/1ps
`default_nettype none
module lbtd_lin_node #(
	parameter int unsigned BIT_CYC = 2500
) (
	input wire logic sys_clk, // bench clock
	input wire logic invertPol, // line sense
	output logic linLine // bus line
);
	// ****
	// line driver
	// ****
	logic dom = 1'b0;
	assign linLine = dom ^ ~invertPol;
	task automatic hold(input logic lvl, input int unsigned n);
		dom = lvl;
		repeat (n) @(negedge sys_clk);
	endtask : hold
	task automatic sendByte(input logic [7:0] b);
		hold(1'b1, BIT_CYC);
		for (int i = 0; i < 8; i++) begin
			hold(~b[i], BIT_CYC);
		end
		hold(1'b0, BIT_CYC);
	endtask : sendByte
	function automatic logic [7:0] pidOf(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction : pidOf
	// break of 12 bits clears the 11-bit threshold whatever the tick phase
	task automatic sendHeader();
		hold(1'b1, 12 * BIT_CYC);
		hold(1'b0, BIT_CYC);
		sendByte(8'h55);
	endtask : sendHeader
endmodule : lbtd_lin_node
`default_nettype wire

// ### bench/test_lbtd_decoder.sv
// self-checking bench for the lin trigger decoder
`timescale 1ns/1ps
`default_nettype none
module test_lbtd_decoder;
	logic sys_clk = 1'b0, rst_b = 1'b0, invertPol = 1'b0, enParityErr = 1'b0, enSyncErr = 1'b0, enChecksumErr = 1'b0;
	logic [1:0] linStd = 2'h0, idCond = 2'h0, dataCond = 2'h0;
	logic [2:0] trigType = 3'h0, patBytes = 3'h1;
	logic [3:0] dataPosition = 4'h0;
	logic [5:0] identLowerBound = 6'h00, identUpperBound = 6'h00, id;
	logic [14:0] bitRate = 15'h4e20, bitRateUsed;
	logic [31:0] dataPattern = 32'h0;
	logic [7:0] protectedIdent;
	logic trigOut, parityErr, syncErr, checksumErr, wakeSeen;
	wire logic linIn;
	int n_fail = 0, checks = 0, nTrig = 0, nWake = 0, nPar = 0, nSync = 0, cyc = 0;
	integer seed = 32'h38e4;
	// ****
	// harness
	// ****
	initial forever #10 sys_clk = ~sys_clk;
	lbtd_lin_node node (.sys_clk(sys_clk), .invertPol(invertPol), .linLine(linIn));
	lbtd_decoder #(.WAKE_CYC(50)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .linIn(linIn), .invertPol(invertPol),
		.linStd(linStd), .bitRate(bitRate), .trigType(trigType), .idCond(idCond), .identLowerBound(identLowerBound),
		.identUpperBound(identUpperBound), .dataCond(dataCond), .dataPattern(dataPattern), .patBytes(patBytes),
		.dataPosition(dataPosition), .enParityErr(enParityErr), .enSyncErr(enSyncErr),
		.enChecksumErr(enChecksumErr), .trigOut(trigOut), .protectedIdent(protectedIdent), .parityErr(parityErr),
		.syncErr(syncErr), .checksumErr(checksumErr), .wakeSeen(wakeSeen), .bitRateUsed(bitRateUsed));
	// pulses are counted so a late or doubled one shows
	always @(posedge sys_clk) begin
		nTrig += int'(trigOut === 1'b1);
		nWake += int'(wakeSeen === 1'b1);
		nPar += int'(parityErr === 1'b1);
		nSync += int'(syncErr === 1'b1);
		cyc++;
		if (cyc == 100000) begin
			n_fail++;
			summarize();
		end
	end
	function automatic logic [14:0] expRate(input logic [1:0] s, input logic [14:0] r);
		return (s == 2'h2) ? lbtd_pkg::J2602_RATE_BPS : (r > lbtd_pkg::MAX_RATE_BPS ? lbtd_pkg::MAX_RATE_BPS : r);
	endfunction : expRate
	function automatic logic expHit(input logic [5:0] v);
		logic inR;
		inR = v >= identLowerBound && v <= identUpperBound;
		return idCond[1] ? inR ^ idCond[0] : (v == identLowerBound) ^ idCond[0];
	endfunction : expHit
	task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			linStd = (i < 3) ? 2'h0 : (i == 3) ? 2'h2 : 2'($random(seed));
			bitRate = (i == 0) ? 15'h4e20 : (i == 1) ? 15'h4e21 : (i == 2) ? 15'h0 : 15'($random(seed));
			repeat (5) @(negedge sys_clk);
			check("bitRateUsed", bitRateUsed, expRate(linStd, bitRate));
		end
		$display("rate test done");
		linStd = 2'h0;
		bitRate = 15'h4e20;
		trigType = 3'h3;
		// last pass is too short to count as wakeup
		for (int i = 0; i < 3; i++) begin
			invertPol = i[0];
			repeat (4) @(negedge sys_clk);
			nWake = 0;
			nTrig = 0;
			node.hold(1'b1, i == 2 ? 20 : 100);
			node.hold(1'b0, 60);
			check("wakeSeen", 15'(nWake), i == 2 ? 15'h0 : 15'h1);
			check("trigOut", 15'(nTrig), i == 2 ? 15'h0 : 15'h1);
		end
		$display("wake test done");
		invertPol = 1'b0;
		trigType = 3'h0;
		id = 6'($random(seed));
		idCond = 2'($random(seed));
		identLowerBound = id ^ 6'($random(seed) & 1);
		identUpperBound = 6'($random(seed));
		{dataCond, patBytes, dataPosition} = 9'($random(seed));
		dataPattern = $random(seed);
		{enParityErr, enSyncErr, enChecksumErr} = 3'($random(seed));
		nTrig = 0;
		nPar = 0;
		nSync = 0;
		node.sendHeader();
		check("trigOut", 15'(nTrig), 15'h1);
		$display("start of frame test done");
		trigType = 3'h1;
		nTrig = 0;
		node.sendByte(node.pidOf(id));
		node.hold(1'b0, 2500);
		check("trigOut", 15'(nTrig), 15'(expHit(id)));
		check("protectedIdent", 15'(protectedIdent), 15'(node.pidOf(id)));
		check("parityErr", 15'(nPar), 15'h0);
		check("syncErr", 15'(nSync), 15'h0);
		$display("ident test done");
		summarize();
	end
endmodule : test_lbtd_decoder
`default_nettype wire

// ### logic/lbtd_decoder.sv
// lin bus receiver, frame decoder and trigger logic
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: recessive idle maps high, polarity selectable
// RQ2: bit rate configurable, clamped to maximum
// RQ3: J2602 forces fixed bit rate
// RQ4: standard setting picks checksum variant, auto
// RQ5: start-of-frame trigger at sync stop bit
// RQ6: plain six-bit identifier compared, value/range
// RQ7: lower/upper bounds, inside or outside range
// RQ8: identifier and data both, fire last byte
// RQ9: data equal, not equal, smaller, bigger
// RQ10: skip configured data bytes before checking
// RQ11: wakeup frame detection raises trigger
// RQ12: parity in bits six, seven checked
// RQ13: last byte checksum over data, identifier; for V1 only the classic data-only sum is checked
// RQ14: error trigger on any enabled error
// RQ15: centre sampling, resync on start edge
module lbtd_decoder #(
	parameter int unsigned WAKE_CYC = lbtd_pkg::WAKE_MIN_CYC
) (
	input wire logic sys_clk, // 50 MHz clock
	input wire logic rst_b, // async reset, low
	input wire logic linIn, // sampled bus line
	input wire logic invertPol, // 1: line low means recessive
	input wire logic [1:0] linStd, // standard version
	input wire logic [14:0] bitRate, // bit rate in bit/s
	input wire logic [2:0] trigType, // trigger type
	input wire logic [1:0] idCond, // identifier condition
	input wire logic [5:0] identLowerBound, // identifier value or lower bound
	input wire logic [5:0] identUpperBound, // identifier upper bound
	input wire logic [1:0] dataCond, // data condition
	input wire logic [31:0] dataPattern, // pattern, first byte highest
	input wire logic [2:0] patBytes, // pattern length 1..4 bytes
	input wire logic [3:0] dataPosition, // data bytes skipped
	input wire logic enParityErr, // parity error enable
	input wire logic enSyncErr, // sync error enable
	input wire logic enChecksumErr, // checksum error enable
	output logic trigOut, // trigger pulse
	output logic [7:0] protectedIdent, // last protected identifier
	output logic parityErr, // parity error pulse
	output logic syncErr, // sync error pulse
	output logic checksumErr, // checksum error pulse
	output logic wakeSeen, // wakeup pulse
	output logic [14:0] bitRateUsed // effective bit rate
);
	// ***********************************
	// functions
	// ***********************************
	function automatic logic [7:0] addCarry(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction : addCarry

	function automatic logic parityGood(input logic [7:0] p);
		return (p[lbtd_pkg::PAR0_POS] == (p[0] ^ p[1] ^ p[2] ^ p[4])) &&
			(p[lbtd_pkg::PAR1_POS] == ~(p[1] ^ p[3] ^ p[4] ^ p[5]));
	endfunction : parityGood

	function automatic logic [31:0] byteMask(input logic [2:0] n);
		// lengths above four saturate to the full word
		return (n >= 3'h4) ? 32'hffffffff : (n == 3'h3) ? 32'h00ffffff : (n == 3'h2) ? 32'h0000ffff : 32'h000000ff;
	endfunction : byteMask

	// ***********************************
	// reset release and line level
	// ***********************************
	logic rstMeta_b, rstSync_b;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	logic lineHigh;
	// RQ1 polarity mapping
	assign lineHigh = linIn ^ invertPol;

	// RQ3 J2602 rate forced
	// RQ2 rate clamped
	logic [14:0] rate;
	assign rate = (linStd == lbtd_pkg::STD_J2602) ? lbtd_pkg::J2602_RATE_BPS :
		((bitRate > lbtd_pkg::MAX_RATE_BPS) ? lbtd_pkg::MAX_RATE_BPS : bitRate);

	// ***********************************
	// receiver
	// ***********************************
	typedef enum logic [1:0] {R_IDLE = 2'h0, R_START = 2'h1, R_DATA = 2'h2, R_STOP = 2'h3} lbtd_rx_e;
	lbtd_rx_e rxState_r, rxState_nxt;
	logic [26:0] acc_r, acc_nxt;
	logic [3:0] tickCnt_r, tickCnt_nxt;
	logic [2:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic prevHigh_r, prevHigh_nxt;
	logic [11:0] lowTicks_r, lowTicks_nxt;
	logic [16:0] lowCyc_r, lowCyc_nxt;
	logic tick, byteDone, breakSeen, wakeDet;
	logic [26:0] accSum;

	always_comb begin
		accSum = acc_r + 27'(rate * lbtd_pkg::OVERSAMPLE);
		tick = (accSum >= 27'(lbtd_pkg::CLK_HZ));
		acc_nxt = tick ? accSum - 27'(lbtd_pkg::CLK_HZ) : accSum;
		rxState_nxt = rxState_r;
		tickCnt_nxt = tick ? tickCnt_r + 4'h1 : tickCnt_r;
		bitCnt_nxt = bitCnt_r;
		shift_nxt = shift_r;
		byteDone = 1'b0;
		prevHigh_nxt = lineHigh;
		lowTicks_nxt = lineHigh ? 12'h000 : ((tick && lowTicks_r != 12'hfff) ? lowTicks_r + 12'h001 : lowTicks_r);
		lowCyc_nxt = lineHigh ? 17'h00000 : ((lowCyc_r != 17'h1ffff) ? lowCyc_r + 17'h00001 : lowCyc_r);
		breakSeen = lineHigh && !prevHigh_r && (lowTicks_r >= lbtd_pkg::BREAK_TICKS);
		// RQ11 wakeup pulse shorter than break
		wakeDet = lineHigh && !prevHigh_r && (lowCyc_r >= 17'(WAKE_CYC)) && (lowTicks_r < lbtd_pkg::BREAK_TICKS);
		unique case (rxState_r)
			R_IDLE: begin
				// RQ15 resync on falling edge
				if (prevHigh_r && !lineHigh) begin
					rxState_nxt = R_START;
					tickCnt_nxt = 4'h0;
				end
			end
			R_START: begin
				// RQ15 centre of start bit
				if (tick && tickCnt_r == lbtd_pkg::MID_TICK) begin
					rxState_nxt = lineHigh ? R_IDLE : R_DATA;
					tickCnt_nxt = 4'h0;
					bitCnt_nxt = 3'h0;
				end
			end
			R_DATA: begin
				if (tick && tickCnt_r == lbtd_pkg::LAST_TICK) begin
					shift_nxt = {lineHigh, shift_r[7:1]};
					bitCnt_nxt = bitCnt_r + 3'h1;
					if (bitCnt_r == 3'h7) begin
						rxState_nxt = R_STOP;
					end
				end
			end
			R_STOP: begin
				// stop low means break or framing fault, byte dropped
				if (tick && tickCnt_r == lbtd_pkg::LAST_TICK) begin
					byteDone = lineHigh;
					rxState_nxt = R_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			rxState_r <= R_IDLE;
			acc_r <= 27'h0000000;
			tickCnt_r <= 4'h0;
			bitCnt_r <= 3'h0;
			shift_r <= 8'h00;
			prevHigh_r <= 1'b1;
			lowTicks_r <= 12'h000;
			lowCyc_r <= 17'h00000;
		end else begin
			rxState_r <= rxState_nxt;
			acc_r <= acc_nxt;
			tickCnt_r <= tickCnt_nxt;
			bitCnt_r <= bitCnt_nxt;
			shift_r <= shift_nxt;
			prevHigh_r <= prevHigh_nxt;
			lowTicks_r <= lowTicks_nxt;
			lowCyc_r <= lowCyc_nxt;
		end
	end

	// ***********************************
	// frame decoder and triggers
	// ***********************************
	typedef enum logic [1:0] {F_IDLE = 2'h0, F_SYNC = 2'h1, F_PID = 2'h2, F_DATA = 2'h3} lbtd_frm_e;
	lbtd_frm_e fState_r, fState_nxt;
	logic [7:0] pid_r, pid_nxt, sum_r, sum_nxt;
	logic idOk_r, idOk_nxt;
	logic [3:0] dataIdx_r, dataIdx_nxt;
	logic [31:0] window_r, window_nxt;
	logic [7:0] gap_r, gap_nxt;
	logic trig_nxt, parErr_nxt, syncErr_nxt, sumErr_nxt;
	logic idHit, dataHit, sumClassicOk, sumEnhOk, sumGood, endFrame;
	logic [31:0] mask, winMasked, patMasked;
	logic [4:0] lastIdx;

	always_comb begin
		fState_nxt = fState_r;
		pid_nxt = pid_r;
		sum_nxt = sum_r;
		idOk_nxt = idOk_r;
		dataIdx_nxt = dataIdx_r;
		window_nxt = window_r;
		trig_nxt = 1'b0;
		parErr_nxt = 1'b0;
		syncErr_nxt = 1'b0;
		sumErr_nxt = 1'b0;
		gap_nxt = (rxState_r != R_IDLE) ? 8'h00 : ((tick && gap_r != 8'hff) ? gap_r + 8'h01 : gap_r);
		// RQ6 plain identifier only
		// RQ7 range inside or outside
		unique case (idCond)
			lbtd_pkg::ID_EQ: idHit = (shift_r[5:0] == identLowerBound);
			lbtd_pkg::ID_NE: idHit = (shift_r[5:0] != identLowerBound);
			lbtd_pkg::ID_IN: idHit = (shift_r[5:0] >= identLowerBound) && (shift_r[5:0] <= identUpperBound);
			lbtd_pkg::ID_OUT: idHit = (shift_r[5:0] < identLowerBound) || (shift_r[5:0] > identUpperBound);
		endcase
		mask = byteMask(patBytes);
		winMasked = {window_r[23:0], shift_r} & mask;
		patMasked = dataPattern & mask;
		// RQ9 data comparison
		unique case (dataCond)
			lbtd_pkg::DAT_EQ: dataHit = (winMasked == patMasked);
			lbtd_pkg::DAT_NE: dataHit = (winMasked != patMasked);
			lbtd_pkg::DAT_LT: dataHit = (winMasked < patMasked);
			lbtd_pkg::DAT_GT: dataHit = (winMasked > patMasked);
		endcase
		// RQ10 skip position bytes first
		lastIdx = {1'b0, dataPosition} + {2'b00, ((patBytes == 3'h0) ? 3'h1 : patBytes)} - 5'h01;
		// RQ13 enhanced checksum covers data and identifier, classic covers data only
		sumClassicOk = (sum_r == lbtd_pkg::SUM_OK);
		sumEnhOk = (addCarry(sum_r, pid_r) == lbtd_pkg::SUM_OK);
		// RQ4 checksum variant by standard
		unique case (linStd)
			lbtd_pkg::STD_V1: sumGood = sumClassicOk;
			lbtd_pkg::STD_V2, lbtd_pkg::STD_J2602: sumGood = sumEnhOk;
			lbtd_pkg::STD_AUTO: sumGood = sumClassicOk || sumEnhOk;
		endcase
		// frame ends after an idle gap; the last byte was the checksum
		endFrame = (fState_r == F_DATA) && (rxState_r == R_IDLE) && (gap_r == lbtd_pkg::GAP_TICKS) && tick;
		if (breakSeen) begin
			fState_nxt = F_SYNC;
		end else if (endFrame) begin
			fState_nxt = F_IDLE;
			if (dataIdx_r >= 4'h2) begin
				sumErr_nxt = !sumGood;
			end
		end else if (byteDone) begin
			unique case (fState_r)
				F_IDLE: fState_nxt = F_IDLE;
				F_SYNC: begin
					if (shift_r == lbtd_pkg::SYNC_BYTE) begin
						fState_nxt = F_PID;
						// RQ5 trigger at sync stop bit
						trig_nxt = (trigType == lbtd_pkg::TRG_SOF);
					end else begin
						fState_nxt = F_IDLE;
						syncErr_nxt = 1'b1;
					end
				end
				F_PID: begin
					fState_nxt = F_DATA;
					pid_nxt = shift_r;
					idOk_nxt = idHit;
					dataIdx_nxt = 4'h0;
					sum_nxt = lbtd_pkg::SUM_RESET;
					window_nxt = 32'h00000000;
					// RQ12 parity bits checked
					parErr_nxt = !parityGood(shift_r);
					trig_nxt = (trigType == lbtd_pkg::TRG_ID) && idHit;
				end
				F_DATA: begin
					sum_nxt = addCarry(sum_r, shift_r);
					window_nxt = {window_r[23:0], shift_r};
					dataIdx_nxt = (dataIdx_r != 4'hf) ? dataIdx_r + 4'h1 : dataIdx_r;
					// RQ8 identifier and data, last byte
					trig_nxt = (trigType == lbtd_pkg::TRG_IDDATA) && idOk_r && dataHit &&
						({1'b0, dataIdx_r} == lastIdx);
				end
			endcase
		end
		if (wakeDet && trigType == lbtd_pkg::TRG_WAKE) begin
			trig_nxt = 1'b1;
		end
		// RQ14 any enabled error
		if (trigType == lbtd_pkg::TRG_ERR) begin
			trig_nxt = (parErr_nxt && enParityErr) || (syncErr_nxt && enSyncErr) || (sumErr_nxt && enChecksumErr);
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			fState_r <= F_IDLE;
			pid_r <= 8'h00;
			sum_r <= lbtd_pkg::SUM_RESET;
			idOk_r <= 1'b0;
			dataIdx_r <= 4'h0;
			window_r <= 32'h00000000;
			gap_r <= 8'h00;
			trigOut <= 1'b0;
			parityErr <= 1'b0;
			syncErr <= 1'b0;
			checksumErr <= 1'b0;
			wakeSeen <= 1'b0;
			bitRateUsed <= 15'h0000;
		end else begin
			fState_r <= fState_nxt;
			pid_r <= pid_nxt;
			sum_r <= sum_nxt;
			idOk_r <= idOk_nxt;
			dataIdx_r <= dataIdx_nxt;
			window_r <= window_nxt;
			gap_r <= gap_nxt;
			trigOut <= trig_nxt;
			parityErr <= parErr_nxt;
			syncErr <= syncErr_nxt;
			checksumErr <= sumErr_nxt;
			wakeSeen <= wakeDet;
			bitRateUsed <= rate;
		end
	end

	assign protectedIdent = pid_r;
endmodule : lbtd_decoder

`default_nettype wire

// ### logic/lbtd_decoder_end.sv
// no logic here: the whole decoder lives in lbtd_decoder.sv

// ### logic/lbtd_pkg.sv
// shared constants for the lin bus trigger decoder
package lbtd_pkg;
	// ***********************************
	// clock and timing
	// ***********************************
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [14:0] MAX_RATE_BPS = 15'h4e20; // 20 kbit/s
	localparam logic [14:0] J2602_RATE_BPS = 15'h28b1; // 10.417 kbit/s
	localparam int unsigned WAKE_MIN_US = 250;
	localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_US * (CLK_HZ / 1000000));
	localparam int unsigned BREAK_BITS = 11;
	localparam logic [11:0] BREAK_TICKS = 12'(BREAK_BITS * OVERSAMPLE);
	localparam int unsigned GAP_BITS = 4;
	localparam logic [7:0] GAP_TICKS = 8'(GAP_BITS * OVERSAMPLE);
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	// ***********************************
	// frame constants and reset values
	// ***********************************
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam logic [7:0] SUM_OK = 8'hff;
	localparam logic [7:0] SUM_RESET = 8'h00;
	localparam int unsigned PAR0_POS = 6;
	localparam int unsigned PAR1_POS = 7;
	// ***********************************
	// modes
	// ***********************************
	typedef enum logic [1:0] {STD_V1 = 2'h0, STD_V2 = 2'h1, STD_J2602 = 2'h2, STD_AUTO = 2'h3} lbtd_std_e;
	typedef enum logic [2:0] {TRG_SOF = 3'h0, TRG_ID = 3'h1, TRG_IDDATA = 3'h2, TRG_WAKE = 3'h3,
		TRG_ERR = 3'h4} lbtd_trig_e;
	typedef enum logic [1:0] {ID_EQ = 2'h0, ID_NE = 2'h1, ID_IN = 2'h2, ID_OUT = 2'h3} lbtd_idcond_e;
	typedef enum logic [1:0] {DAT_EQ = 2'h0, DAT_NE = 2'h1, DAT_LT = 2'h2, DAT_GT = 2'h3} lbtd_dcond_e;
endpackage : lbtd_pkg
